// File: logic/cob_pkg.sv
// Purpose: constants for the charger option control bits block
// Assumes: register port carries the 8-bit command code and 16-bit word of the host bus
// Notes:   only bits 7..0 of the option register live here; bits 15..8 read as zero
package cob_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  COB_OFS_OPTION0       = 8'h12;
	localparam int          COB_WORD_W            = 16;
	localparam int          COB_FIELD_W           = 8;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int          COB_BIT_REG_EN        = 1;
	localparam int          COB_BIT_LINEAR        = 2;
	localparam int          COB_BIT_BAT_GAIN      = 3;
	localparam int          COB_BIT_IN_GAIN       = 4;
	localparam int          COB_BIT_LEARN         = 5;

	// ----------------------------------------------------------------
	// reset value of bits 7..0: linear, battery gain 16x, regulation on
	// ----------------------------------------------------------------
	localparam logic [7:0]  COB_RST_FIELD         = 8'h0E;

	// ----------------------------------------------------------------
	// amplifier ratios and pre-charge clamps
	// ----------------------------------------------------------------
	localparam logic [7:0]  COB_IN_GAIN_LO        = 8'h14;   // 20x
	localparam logic [7:0]  COB_IN_GAIN_HI        = 8'h28;   // 40x
	localparam logic [7:0]  COB_BAT_GAIN_LO       = 8'h08;   // 8x
	localparam logic [7:0]  COB_BAT_GAIN_HI       = 8'h10;   // 16x
	localparam logic [15:0] COB_CLAMP_MULTI_MA    = 16'h0180; // 384 mA, 2 to 4 cells
	localparam logic [15:0] COB_CLAMP_ONE_MA      = 16'h07D0; // 2000 mA, 1 cell

	// ----------------------------------------------------------------
	// system regulation reference
	// ----------------------------------------------------------------
	localparam logic        COB_SYSREF_MAX_CHARGE = 1'b0;
	localparam logic        COB_SYSREF_MIN_SYSTEM = 1'b1;

endpackage

// File: logic/cob_pin_sync.sv
// Purpose: three-flop synchroniser with agreement filter for the battery-present pin
// Assumes: pin is asynchronous to clock_in
// Notes:   filtered level changes only when the second and third stages agree
module cob_pin_sync (
	input  wire logic clock_in,
	input  wire logic reset_in,
	input  wire logic ce_in,
	input  wire logic pin_in,
	output logic      level_out,
	output logic      fall_out
);
	import cob_pkg::*;

	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;
	logic nxt_level;

	always_comb begin
		nxt_level = level_ff;
		if (s2_ff == s3_ff) begin
			nxt_level = s3_ff;
		end
	end

	// pin reads as present (high) out of reset so no false falling edge is seen
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			s1_ff    <= 1'b1;
			s2_ff    <= 1'b1;
			s3_ff    <= 1'b1;
			level_ff <= 1'b1;
		end else if (ce_in) begin
			s1_ff    <= pin_in;
			s2_ff    <= s1_ff;
			s3_ff    <= s2_ff;
			level_ff <= nxt_level;
		end
	end

	assign level_out = level_ff;
	assign fall_out  = ce_in & level_ff & ~nxt_level;

endmodule // cob_pin_sync

// File: logic/cob_option_ctrl.sv
// Purpose: low control field of the first charger option register and its effects
// Assumes: host accesses arrive as one-cycle strobes with command code and word
// Notes:   hardware clears of learn and regulation enable win over a same-cycle host write
module cob_option_ctrl (
	input  wire logic                         clock_in,
	input  wire logic                         reset_in,
	input  wire logic                         ce_in,
	// register port
	input  wire logic [7:0]                   reg_addr_in,
	input  wire logic                         reg_wr_in,
	input  wire logic                         reg_rd_in,
	input  wire logic [cob_pkg::COB_WORD_W-1:0] reg_wdata_in,
	output logic      [cob_pkg::COB_WORD_W-1:0] reg_rdata_out,
	output logic                              reg_ack_out,
	// status of the charger
	input  wire logic                         battery_present_pin_in,
	input  wire logic                         auto_regulation_disable_in,
	input  wire logic                         regulation_auto_off_in,
	input  wire logic                         adapter_present_in,
	input  wire logic                         battery_below_min_sys_in,
	input  wire logic                         single_cell_in,
	input  wire logic [15:0]                  charge_current_setting_in,
	// controls to the analog loops
	output logic                              learn_mode_enable_out,
	output logic                              learn_discharge_out,
	output logic [7:0]                        input_monitor_gain_select_out,
	output logic [7:0]                        battery_monitor_gain_select_out,
	output logic                              linear_precharge_enable_out,
	output logic                              linear_precharge_active_out,
	output logic                              battery_switch_full_on_out,
	output logic                              system_reg_source_out,
	output logic [15:0]                       precharge_current_limit_out,
	output logic                              input_regulation_enable_out
);
	import cob_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] pick_ratio(input logic sel, input logic [7:0] lo, input logic [7:0] hi);
		pick_ratio = sel ? hi : lo;
	endfunction

	function automatic logic [15:0] clamp_to(input logic [15:0] val, input logic [15:0] lim);
		clamp_to = (val > lim) ? lim : val;
	endfunction

	// ----------------------------------------------------------------
	// battery-present pin
	// ----------------------------------------------------------------
	logic bat_level;
	logic bat_fall;

	cob_pin_sync u_bat_sync (
		.clock_in  (clock_in),
		.reset_in  (reset_in),
		.ce_in     (ce_in),
		.pin_in    (battery_present_pin_in),
		.level_out (bat_level),
		.fall_out  (bat_fall)
	);

	// ----------------------------------------------------------------
	// register field
	// ----------------------------------------------------------------
	logic [7:0]  field_ff;
	logic [7:0]  nxt_field;
	logic        hit;

	// only one command code is mapped; other codes are acknowledged and ignored
	assign hit = (reg_addr_in == COB_OFS_OPTION0);

	always_comb begin
		nxt_field = field_ff;
		if (reg_wr_in && hit) begin
			nxt_field = reg_wdata_in[COB_FIELD_W-1:0];
		end
		// hardware clears come after the host write so a same-cycle clear wins
		if (!bat_level) begin
			nxt_field[COB_BIT_LEARN] = 1'b0;
		end
		if (regulation_auto_off_in) begin
			nxt_field[COB_BIT_REG_EN] = 1'b0;
		end
		// edge based, so the host may re-enable while the pin stays low
		if (auto_regulation_disable_in && bat_fall) begin
			nxt_field[COB_BIT_REG_EN] = 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			field_ff <= COB_RST_FIELD;
		end else if (ce_in) begin
			field_ff <= nxt_field;
		end
	end

	// ----------------------------------------------------------------
	// read answer
	// ----------------------------------------------------------------
	logic [COB_WORD_W-1:0] rdata_ff;
	logic [COB_WORD_W-1:0] nxt_rdata;
	logic                  ack_ff;
	logic                  nxt_ack;

	always_comb begin
		nxt_rdata = rdata_ff;
		nxt_ack   = reg_wr_in | reg_rd_in;
		if (reg_rd_in) begin
			// unmapped codes read as zero
			nxt_rdata = hit ? {8'h00, field_ff} : '0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			rdata_ff <= '0;
			ack_ff   <= 1'b0;
		end else if (ce_in) begin
			rdata_ff <= nxt_rdata;
			ack_ff   <= nxt_ack;
		end
	end

	assign reg_rdata_out = rdata_ff;
	assign reg_ack_out   = ack_ff;

	// ----------------------------------------------------------------
	// learn discharge path
	// ----------------------------------------------------------------
	logic        learn_ff;
	logic        nxt_learn;

	// discharge only matters with the adapter in; without it the battery feeds the system anyway
	always_comb begin
		nxt_learn = field_ff[COB_BIT_LEARN] & adapter_present_in;
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			learn_ff <= 1'b0;
		end else if (ce_in) begin
			learn_ff <= nxt_learn;
		end
	end

	// ----------------------------------------------------------------
	// monitor amplifier ratios
	// ----------------------------------------------------------------
	logic [7:0]  in_gain_ff;
	logic [7:0]  nxt_in_gain;
	logic [7:0]  bat_gain_ff;
	logic [7:0]  nxt_bat_gain;

	// ratios go out as plain multipliers for the analog trim
	always_comb begin
		nxt_in_gain  = pick_ratio(field_ff[COB_BIT_IN_GAIN], COB_IN_GAIN_LO, COB_IN_GAIN_HI);
		nxt_bat_gain = pick_ratio(field_ff[COB_BIT_BAT_GAIN], COB_BAT_GAIN_LO, COB_BAT_GAIN_HI);
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			in_gain_ff  <= COB_IN_GAIN_LO;
			bat_gain_ff <= COB_BAT_GAIN_HI;
		end else if (ce_in) begin
			in_gain_ff  <= nxt_in_gain;
			bat_gain_ff <= nxt_bat_gain;
		end
	end

	// ----------------------------------------------------------------
	// pre-charge and system regulation source
	// ----------------------------------------------------------------
	logic        lin_act_ff;
	logic        nxt_lin_act;
	logic        sw_on_ff;
	logic        nxt_sw_on;
	logic        sysref_ff;
	logic        nxt_sysref;
	logic [15:0] pre_lim_ff;
	logic [15:0] nxt_pre_lim;

	// with linear mode off the pack resistance sets pre-charge current, so no limit is driven
	always_comb begin
		nxt_lin_act  = field_ff[COB_BIT_LINEAR] & battery_below_min_sys_in;
		nxt_sw_on    = ~field_ff[COB_BIT_LINEAR];
		nxt_sysref   = COB_SYSREF_MAX_CHARGE;
		nxt_pre_lim  = '0;
		if (field_ff[COB_BIT_LINEAR]) begin
			nxt_sysref = COB_SYSREF_MIN_SYSTEM;
			nxt_pre_lim = clamp_to(charge_current_setting_in,
				single_cell_in ? COB_CLAMP_ONE_MA : COB_CLAMP_MULTI_MA);
		end
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			lin_act_ff  <= 1'b0;
			sw_on_ff    <= 1'b0;
			sysref_ff   <= COB_SYSREF_MIN_SYSTEM;
			pre_lim_ff  <= '0;
		end else if (ce_in) begin
			lin_act_ff  <= nxt_lin_act;
			sw_on_ff    <= nxt_sw_on;
			sysref_ff   <= nxt_sysref;
			pre_lim_ff  <= nxt_pre_lim;
		end
	end

	assign learn_mode_enable_out           = field_ff[COB_BIT_LEARN];
	assign learn_discharge_out             = learn_ff;
	assign input_monitor_gain_select_out   = in_gain_ff;
	assign battery_monitor_gain_select_out = bat_gain_ff;
	assign linear_precharge_enable_out     = field_ff[COB_BIT_LINEAR];
	assign linear_precharge_active_out     = lin_act_ff;
	assign battery_switch_full_on_out      = sw_on_ff;
	assign system_reg_source_out           = sysref_ff;
	assign precharge_current_limit_out     = pre_lim_ff;
	assign input_regulation_enable_out     = field_ff[COB_BIT_REG_EN];

endmodule // cob_option_ctrl

// File: tb/cob_option_ctrl_properties.sv
// Purpose: concurrent checks on the option control bits
// Assumes: ce_in high in normal running
// Notes:   bound to the top module
module cob_option_ctrl_properties (
	input wire logic	clock_in,
	input wire logic	reset_in,
	input wire logic	ce_in,
	input wire logic [7:0]	reg_addr_in,
	input wire logic	reg_wr_in,
	input wire logic [cob_pkg::COB_WORD_W-1:0]	reg_wdata_in,
	input wire logic	battery_present_pin_in,
	input wire logic	auto_regulation_disable_in,
	input wire logic	regulation_auto_off_in,
	input wire logic	adapter_present_in,
	input wire logic	learn_mode_enable_out,
	input wire logic	learn_discharge_out,
	input wire logic [7:0]	input_monitor_gain_select_out,
	input wire logic [7:0]	battery_monitor_gain_select_out,
	input wire logic	linear_precharge_enable_out,
	input wire logic	battery_switch_full_on_out,
	input wire logic	system_reg_source_out,
	input wire logic	input_regulation_enable_out
);
	import cob_pkg::*;
	logic wr_opt;
	assign wr_opt = ce_in && reg_wr_in && reg_addr_in == COB_OFS_OPTION0;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);
	property p_learn_dis; ce_in && learn_mode_enable_out && adapter_present_in |=> learn_discharge_out; endproperty
	a_learn_dis: assert property (p_learn_dis) else $error("learn discharge missing");
	property p_learn_pin; (ce_in && !battery_present_pin_in) [*7] |-> !learn_mode_enable_out; endproperty
	a_learn_pin: assert property (p_learn_pin) else $error("learn kept with pin low");
	property p_in_gain; wr_opt |=> ##1 input_monitor_gain_select_out ==
		($past(reg_wdata_in[COB_BIT_IN_GAIN], 2) ? COB_IN_GAIN_HI : COB_IN_GAIN_LO); endproperty
	a_in_gain: assert property (p_in_gain) else $error("input gain wrong");
	property p_bat_gain; wr_opt |=> ##1 battery_monitor_gain_select_out ==
		($past(reg_wdata_in[COB_BIT_BAT_GAIN], 2) ? COB_BAT_GAIN_HI : COB_BAT_GAIN_LO); endproperty
	a_bat_gain: assert property (p_bat_gain) else $error("battery gain wrong");
	property p_switch; ce_in |=> battery_switch_full_on_out != $past(linear_precharge_enable_out); endproperty
	a_switch: assert property (p_switch) else $error("switch state wrong");
	property p_sys_ref; ce_in |=> system_reg_source_out == $past(linear_precharge_enable_out); endproperty
	a_sys_ref: assert property (p_sys_ref) else $error("system reference wrong");
	property p_auto_off; ce_in && regulation_auto_off_in |=> !input_regulation_enable_out; endproperty
	a_auto_off: assert property (p_auto_off) else $error("regulation not cleared");
	property p_pin_reg; $fell(battery_present_pin_in) ##0 (ce_in && auto_regulation_disable_in &&
		!battery_present_pin_in && !reg_wr_in) [*7] |-> !input_regulation_enable_out; endproperty
	a_pin_reg: assert property (p_pin_reg) else $error("regulation kept on removal");
	c_learn: cover property (learn_discharge_out);
	c_reg_off: cover property ($fell(input_regulation_enable_out));
	c_switch: cover property ($rose(battery_switch_full_on_out));
endmodule // cob_option_ctrl_properties

bind cob_option_ctrl cob_option_ctrl_properties i_props (.clock_in(clock_in), .reset_in(reset_in), .ce_in(ce_in),
	.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
	.battery_present_pin_in(battery_present_pin_in), .auto_regulation_disable_in(auto_regulation_disable_in),
	.regulation_auto_off_in(regulation_auto_off_in), .adapter_present_in(adapter_present_in),
	.learn_mode_enable_out(learn_mode_enable_out), .learn_discharge_out(learn_discharge_out),
	.input_monitor_gain_select_out(input_monitor_gain_select_out),
	.battery_monitor_gain_select_out(battery_monitor_gain_select_out),
	.linear_precharge_enable_out(linear_precharge_enable_out),
	.battery_switch_full_on_out(battery_switch_full_on_out), .system_reg_source_out(system_reg_source_out),
	.input_regulation_enable_out(input_regulation_enable_out));

// File: tb/cob_host_model.sv
// Purpose: host issuing one-cycle strobes on the register port
// Assumes: changes off the falling edge
// Notes:   released address and data lines show the inverse of the last value; both strobes go low
module cob_host_model (
	input  wire logic	clock_in,
	input  wire logic	ack_in,
	output logic [7:0]	addr_out,
	output logic	wr_out,
	output logic	rd_out,
	output logic [15:0]	wdata_out,
	output logic	timeout_out
);
	initial {addr_out, wr_out, rd_out, wdata_out, timeout_out} = 27'h0;
	task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		@(negedge clock_in);
		{addr_out, wdata_out, wr_out, rd_out} = {a, d, w, !w};
		@(negedge clock_in);
		{addr_out, wdata_out, wr_out, rd_out} = {~a, ~d, 2'b00};
		for (n = 0; n < 8 && ack_in !== 1'b1; n++) @(negedge clock_in);
		if (ack_in !== 1'b1) timeout_out = 1'b1;
	endtask
endmodule // cob_host_model

// File: tb/charger_option_control_bits_tb.sv
// Purpose: directed bench for the option control bits
// Assumes: ce_in held high except for two cycles dropped with aoff raised
// Notes:   register traffic goes through the host model
module charger_option_control_bits_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, ce, wr, rd, ack, tmo, pin, adis, aoff, adp, below, single, learn, ldis, lin, lact, sw, sref, ren;
	logic [7:0] addr, ig, bg;
	logic [15:0] wdata, rdata, cur, lim;
	int failures = 0;
	int tests_run = 0;
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	cob_host_model i_host (.clock_in(clk), .ack_in(ack), .addr_out(addr), .wr_out(wr), .rd_out(rd),
		.wdata_out(wdata), .timeout_out(tmo));
	cob_option_ctrl i_dut (.clock_in(clk), .reset_in(rst), .ce_in(ce), .reg_addr_in(addr), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_ack_out(ack), .adapter_present_in(adp),
		.battery_present_pin_in(pin), .auto_regulation_disable_in(adis), .regulation_auto_off_in(aoff),
		.battery_below_min_sys_in(below), .single_cell_in(single), .charge_current_setting_in(cur),
		.learn_mode_enable_out(learn), .learn_discharge_out(ldis), .input_monitor_gain_select_out(ig),
		.battery_monitor_gain_select_out(bg), .linear_precharge_enable_out(lin), .linear_precharge_active_out(lact),
		.battery_switch_full_on_out(sw), .system_reg_source_out(sref), .precharge_current_limit_out(lim),
		.input_regulation_enable_out(ren));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		i_host.access(1'b0, a, 16'h0000);
		chk(rdata, exp);
	endtask
	task automatic results;
		if (tmo === 1'b1) failures++;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		{rst, pin, adis, aoff, adp, below, single} = 7'h60;
		ce = 1'b1;
		cur = 16'h0FA0;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		rd_chk(8'h12, 16'h000E);
		chk({ig, bg}, 16'h1410);
		chk({11'h000, lin, sw, sref, ren, learn}, 16'h0016);
		adp = 1'b1;
		i_host.access(1'b1, 8'h12, 16'hFF38);
		rd_chk(8'h12, 16'h0038);
		chk({ig, bg}, 16'h2810);
		chk({10'h000, ldis, lin, sw, sref, ren, learn}, 16'h0029);
		chk(lim, 16'h0000);
		i_host.access(1'b1, 8'h13, 16'h0000);
		rd_chk(8'h13, 16'h0000);
		rd_chk(8'h12, 16'h0038);
		below = 1'b1;
		i_host.access(1'b1, 8'h12, 16'h0006);
		repeat (2) @(negedge clk);
		chk({bg, 6'h00, lact, sref}, 16'h0803);
		chk(lim, 16'h0180);
		single = 1'b1;
		repeat (2) @(negedge clk);
		chk(lim, 16'h07D0);
		cur = 16'h0100;
		repeat (2) @(negedge clk);
		chk(lim, 16'h0100);
		adis = 1'b1;
		i_host.access(1'b1, 8'h12, 16'h0022);
		pin = 1'b0;
		repeat (8) @(negedge clk);
		rd_chk(8'h12, 16'h0000);
		i_host.access(1'b1, 8'h12, 16'h0022);
		rd_chk(8'h12, 16'h0002);
		{ce, aoff} = 2'b01;
		repeat (2) @(negedge clk);
		{ce, aoff} = 2'b10;
		chk({15'h0000, ren}, 16'h0001);
		aoff = 1'b1;
		@(negedge clk);
		aoff = 1'b0;
		rd_chk(8'h12, 16'h0000);
		results;
	end
endmodule // charger_option_control_bits_tb
